// [dv/host_link_model.sv]
// Host side of the three-wire write link: frames words onto the link pins.
// Assumes ref_clk at 40 MHz; the link clock it makes has a 200 ns period.
`timescale 1ns/1ps

module host_link_model (
	input  logic ref_clk,
	output logic frame_select_n,
	output logic serial_data,
	output logic shift_clock
);
	initial
	begin
		frame_select_n = 1'b1;
		serial_data    = 1'b0;
		shift_clock    = 1'b0;
	end

	// Sends the top n bits of word, then extra clocks with toggling data.
	task automatic send(input logic [15:0] word, input int n, input int extra);
		@(posedge ref_clk);
		frame_select_n <= 1'b0;
		// The link clock stands low here, so select never falls with it.
		repeat (4) @(posedge ref_clk);
		for (int i = 0; i < n + extra; i++)
		begin
			shift_clock <= 1'b1;
			serial_data <= (i < n) ? word[15 - i] : ~serial_data;
			repeat (4) @(posedge ref_clk);
			shift_clock <= 1'b0;
			repeat (4) @(posedge ref_clk);
		end
		serial_data <= 1'b0;
		repeat (2) @(posedge ref_clk);
		frame_select_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask
endmodule

// [dv/quad_dac_serial_write_control_test.sv]
// Self-checking bench of the converter control: Wishbone and link frames.
// Assumes the host link model drives the link pins of the design.
`timescale 1ns/1ps

module quad_dac_serial_write_control_test;
	logic                      ref_clk = 1'b0;
	logic                      arst_n = 1'b0;
	logic                      wb_cyc = 1'b0;
	logic                      wb_stb = 1'b0;
	logic                      wb_we = 1'b0;
	logic [7:0]                wb_adr = 8'h00;
	logic [3:0]                wb_sel = 4'h0;
	logic [31:0]               wb_dat_w = 32'h0;
	logic [31:0]               wb_dat_r;
	logic                      wb_ack;
	logic                      frame_select_n;
	logic                      serial_data;
	logic                      shift_clock;
	quad_dac_pkg::code_t [3:0] channel_outputs;
	logic                      powered_down;
	quad_dac_pkg::term_t       termination;
	logic [9:0]                er [4] = '{default: 10'h000};
	logic [9:0]                eo [4] = '{default: 10'h000};
	logic [15:0]               lw;
	int                        n_mismatch = 0;
	int                        check_count = 0;
	int                        cycles = 0;

	always #12.5 ref_clk = ~ref_clk;

	quad_dac_serial_write_control i_quad_dac_serial_write_control (
		.ref_clk         (ref_clk),
		.arst_n          (arst_n),
		.wb_cyc          (wb_cyc),
		.wb_stb          (wb_stb),
		.wb_we           (wb_we),
		.wb_adr          (wb_adr),
		.wb_sel          (wb_sel),
		.wb_dat_w        (wb_dat_w),
		.wb_dat_r        (wb_dat_r),
		.wb_ack          (wb_ack),
		.frame_select_n  (frame_select_n),
		.serial_data     (serial_data),
		.shift_clock     (shift_clock),
		.channel_outputs (channel_outputs),
		.powered_down    (powered_down),
		.termination     (termination)
	);

	host_link_model i_host_link_model (
		.ref_clk        (ref_clk),
		.frame_select_n (frame_select_n),
		.serial_data    (serial_data),
		.shift_clock    (shift_clock)
	);

	task automatic conclude();
		$display("checks %0d, mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge ref_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 12000)
		begin
			n_mismatch++;
			conclude();
		end
	end

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	// One classic cycle; a missing ack counts as a mismatch.
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge ref_clk);
		wb_cyc   <= 1'b1;
		wb_stb   <= 1'b1;
		wb_we    <= we;
		wb_adr   <= a;
		wb_sel   <= 4'hf;
		wb_dat_w <= d;
		@(posedge ref_clk);
		while (wb_ack !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge ref_clk);
		end
		if (n == 50)
			n_mismatch++;
		r = wb_dat_r;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input string what,
		input logic [31:0] exp);
		logic [31:0] r;
		wb(1'b0, a, 32'h0, r);
		check(what, r, exp);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		wb(1'b1, a, d, r);
	endtask

	task automatic chk_all();
		for (int i = 0; i < 4; i++)
		begin
			rd(8'h10 + 8'(4 * i), "channel register", {22'h0, er[i]});
			rd(8'h20 + 8'(4 * i), "output code", {22'h0, eo[i]});
			check("channel output", {22'h0, channel_outputs[i]},
				{22'h0, eo[i]});
		end
	endtask

	// The two trailing data bits are ones, which the code must drop.
	task automatic frame(input logic [1:0] ch, input logic [1:0] op,
		input logic [9:0] code, input int n, input int extra);
		lw = {ch, op, code, 2'b11};
		i_host_link_model.send(lw, n, extra);
		repeat (8) @(posedge ref_clk);
	endtask

	initial
	begin
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		rd(8'h00, "control", 32'h1);
		rd(8'h04, "status", 32'h0);
		rd(8'h40, "unmapped", 32'h0);
		chk_all();
		check("powered down", {31'h0, powered_down}, 32'h0);
		frame(2'b01, 2'b00, 10'h3ff, 16, 0);
		er[1] = 10'h3ff;
		chk_all();
		rd(8'h08, "last word", {16'h0, lw});
		frame(2'b00, 2'b01, 10'h155, 16, 0);
		er[0] = 10'h155;
		eo = er;
		chk_all();
		frame(2'b11, 2'b10, 10'h2aa, 16, 0);
		er = '{default: 10'h2aa};
		eo = er;
		chk_all();
		frame(2'b10, 2'b01, 10'h001, 15, 0);
		chk_all();
		rd(8'h04, "status", 32'h18);
		rd(8'h0c, "frame count", 32'h3);
		frame(2'b11, 2'b00, 10'h001, 16, 5);
		er[3] = 10'h001;
		chk_all();
		rd(8'h08, "last word", {16'h0, lw});
		rd(8'h0c, "frame count", 32'h4);
		for (int t = 0; t < 4; t++)
		begin
			frame(2'(t), 2'b11, 10'h3c3, 16, 0);
			check("powered down", {31'h0, powered_down}, 32'h1);
			check("termination", {30'h0, termination}, 32'(t));
			chk_all();
		end
		wr(8'h04, 32'h18);
		rd(8'h04, "status", 32'h7);
		frame(2'b10, 2'b00, 10'h0f0, 16, 0);
		er[2] = 10'h0f0;
		check("powered down", {31'h0, powered_down}, 32'h0);
		chk_all();
		wr(8'h00, 32'h0);
		frame(2'b00, 2'b10, 10'h111, 16, 0);
		chk_all();
		rd(8'h0c, "frame count", 32'h9);
		wr(8'h00, 32'h1);
		rd(8'h00, "control", 32'h1);
		// A second reset must clear what the frames have loaded.
		arst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		arst_n <= 1'b1;
		er = '{default: 10'h000};
		eo = er;
		chk_all();
		rd(8'h0c, "frame count", 32'h0);
		rd(8'h04, "status", 32'h0);
		conclude();
	end
endmodule

// [hw/frame_shifter.sv]
// Serial frame receiver: synchronises the three link pins to ref_clk,
// finds shift clock falling edges and assembles one 16-bit word per frame.
// Assumes the link clock is slow enough to be seen low and high by ref_clk.
`timescale 1ns/1ps
`include "quad_dac_regs.svh"

module frame_shifter (
	input  logic                     ref_clk,
	input  logic                     arst_n,
	input  logic                     link_enable,
	input  logic                     frame_select_n,
	input  logic                     serial_data,
	input  logic                     shift_clock,
	output logic [15:0]              word,
	output logic                     word_valid,
	output logic                     frame_abort
);

	logic [2:0]                      meta;
	logic [2:0]                      sync;
	logic                            fs_prev;
	logic                            sclk_prev;
	logic                            fs_s;
	logic                            data_s;
	logic                            sclk_fall;
	quad_dac_pkg::link_state_t       state;
	quad_dac_pkg::link_state_t       next_state;
	logic [3:0]                      count;
	logic [3:0]                      next_count;
	logic [15:0]                     next_word;
	logic                            next_valid;
	logic                            next_abort;

	// Pins pass two flip-flops; edges are found on the second stage only.
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			meta      <= 3'h4;
			sync      <= 3'h4;
			fs_prev   <= 1'b1;
			sclk_prev <= 1'b0;
		end
		else
		begin
			meta      <= {frame_select_n, serial_data, shift_clock};
			sync      <= meta;
			fs_prev   <= sync[2];
			sclk_prev <= sync[0];
		end
	end

	assign fs_s      = sync[2];
	assign data_s    = sync[1];
	assign sclk_fall = sclk_prev & ~sync[0];

	always_comb
	begin
		next_state = state;
		next_count = count;
		next_word  = word;
		next_valid = 1'b0;
		next_abort = 1'b0;
		case (state)
			quad_dac_pkg::LINK_IDLE:
			begin
				// A frame opens only on a falling edge of frame select.
				if (link_enable && fs_prev && !fs_s)
				begin
					next_state = quad_dac_pkg::LINK_SHIFT;
					next_count = 4'h0;
				end
			end
			quad_dac_pkg::LINK_SHIFT:
			begin
				if (fs_s || !link_enable)
				begin
					next_state = quad_dac_pkg::LINK_IDLE;
					next_abort = 1'b1;
				end
				else if (sclk_fall)
				begin
					next_word  = {word[14:0], data_s};
					next_count = count + 4'h1;
					if (count == `LAST_BIT_COUNT)
					begin
						next_state = quad_dac_pkg::LINK_DONE;
						next_valid = 1'b1;
					end
				end
			end
			quad_dac_pkg::LINK_DONE:
			begin
				// Further clocks are ignored until frame select rises.
				if (fs_s)
				begin
					next_state = quad_dac_pkg::LINK_IDLE;
				end
			end
			default:
			begin
				next_state = quad_dac_pkg::LINK_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state       <= quad_dac_pkg::LINK_IDLE;
			count       <= 4'h0;
			word        <= 16'h0000;
			word_valid  <= 1'b0;
			frame_abort <= 1'b0;
		end
		else
		begin
			state       <= next_state;
			count       <= next_count;
			word        <= next_word;
			word_valid  <= next_valid;
			frame_abort <= next_abort;
		end
	end

	shift_in_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		state == quad_dac_pkg::LINK_SHIFT && link_enable && !fs_s && sclk_fall
		|=> word == {$past(word[14:0]), $past(data_s)})
		else $error("serial bit not shifted in");

	abort_frame_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		state == quad_dac_pkg::LINK_SHIFT && fs_s
		|=> frame_abort && !word_valid && state == quad_dac_pkg::LINK_IDLE)
		else $error("early frame select rise not aborted");

	done_ignore_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		state == quad_dac_pkg::LINK_DONE && !fs_s
		|=> state == quad_dac_pkg::LINK_DONE && !word_valid && $stable(word))
		else $error("clock after last bit not ignored");

endmodule

// [hw/quad_dac_pkg.sv]
// Types shared by the serial frame shifter and the converter control.
// Assumes nothing of its surroundings.
package quad_dac_pkg;

	typedef enum logic [1:0]
	{
		LINK_IDLE  = 2'b00,
		LINK_SHIFT = 2'b01,
		LINK_DONE  = 2'b10
	} link_state_t;

	typedef enum logic [1:0]
	{
		OP_LOAD        = 2'b00,
		OP_LOAD_UPDATE = 2'b01,
		OP_LOAD_ALL    = 2'b10,
		OP_POWER_DOWN  = 2'b11
	} op_mode_t;

	typedef enum logic [1:0]
	{
		TERM_HIGH_Z     = 2'b00,
		TERM_2K5        = 2'b01,
		TERM_100K       = 2'b10,
		TERM_HIGH_Z_ALT = 2'b11
	} term_t;

	typedef logic [9:0] code_t;

endpackage

// [hw/quad_dac_regs.svh]
// Register offsets, field positions and reset values of the converter control.
// Assumes a Wishbone slave with byte addresses on an 8-bit address bus.
`ifndef QUAD_DAC_REGS_SVH
`define QUAD_DAC_REGS_SVH

`define CTRL_OFFSET              8'h00
`define STATUS_OFFSET            8'h04
`define LAST_WORD_OFFSET         8'h08
`define FRAME_COUNT_OFFSET       8'h0c
`define CHANNEL_REG_PAGE         4'h1
`define CHANNEL_OUT_PAGE         4'h2

`define CTRL_LINK_ENABLE_BIT     0
`define CTRL_RESET               1'b1

`define STATUS_POWERED_DOWN_BIT  0
`define STATUS_TERM_LOW_BIT      1
`define STATUS_TERM_HIGH_BIT     2
`define STATUS_ABORT_BIT         3
`define STATUS_FRAME_BIT         4

`define CHANNEL_SELECT_HIGH      15
`define CHANNEL_SELECT_LOW       14
`define OPERATION_FIELD_HIGH     13
`define OPERATION_FIELD_LOW      12
`define CODE_HIGH                11
`define CODE_LOW                 2

`define FRAME_BITS               16
`define LAST_BIT_COUNT           4'hf
`define CODE_RESET               10'h000

`endif

// [hw/quad_dac_serial_write_control.sv]
// Control logic of a quad 10-bit converter with a three-wire write link.
// Assumes a classic Wishbone master on ref_clk and link pins from outside.
`timescale 1ns/1ps
`include "quad_dac_regs.svh"

module quad_dac_serial_write_control (
	input  logic                     ref_clk,
	input  logic                     arst_n,
	input  logic                     wb_cyc,
	input  logic                     wb_stb,
	input  logic                     wb_we,
	input  logic [7:0]               wb_adr,
	input  logic [3:0]               wb_sel,
	input  logic [31:0]              wb_dat_w,
	output logic [31:0]              wb_dat_r,
	output logic                     wb_ack,
	input  logic                     frame_select_n,
	input  logic                     serial_data,
	input  logic                     shift_clock,
	output quad_dac_pkg::code_t [3:0] channel_outputs,
	output logic                     powered_down,
	output quad_dac_pkg::term_t      termination
);

	// Channels loaded by a frame of the given operation and address.
	function automatic logic [3:0] load_mask(
		input quad_dac_pkg::op_mode_t op,
		input logic [1:0]             ch
	);
		case (op)
			quad_dac_pkg::OP_LOAD:        load_mask = 4'h1 << ch;
			quad_dac_pkg::OP_LOAD_UPDATE: load_mask = 4'h1 << ch;
			quad_dac_pkg::OP_LOAD_ALL:    load_mask = 4'hf;
			default:                      load_mask = 4'h0;
		endcase
	endfunction

	// True when the frame moves the registers onto all four outputs.
	function automatic logic updates_outputs(
		input quad_dac_pkg::op_mode_t op
	);
		updates_outputs = (op == quad_dac_pkg::OP_LOAD_UPDATE) ||
			(op == quad_dac_pkg::OP_LOAD_ALL);
	endfunction

	logic [15:0]                     word;
	logic                            word_valid;
	logic                            frame_abort;
	logic                            link_enable;
	logic                            next_link_enable;
	quad_dac_pkg::op_mode_t          op;
	logic [1:0]                      ch;
	quad_dac_pkg::code_t             code;
	logic [3:0]                      mask;
	quad_dac_pkg::code_t [3:0]       channel_reg;
	quad_dac_pkg::code_t [3:0]       next_channel_reg;
	quad_dac_pkg::code_t [3:0]       next_outputs;
	logic                            next_powered_down;
	quad_dac_pkg::term_t             next_termination;
	logic [15:0]                     last_word;
	logic [15:0]                     next_last_word;
	logic [15:0]                     frame_count;
	logic [15:0]                     next_frame_count;
	logic                            abort_seen;
	logic                            next_abort_seen;
	logic                            frame_seen;
	logic                            next_frame_seen;
	logic                            bus_hit;
	logic                            bus_write;
	logic                            next_ack;
	logic [31:0]                     next_dat_r;
	logic [7:0]                      word_adr;

	frame_shifter link (
		.ref_clk        (ref_clk),
		.arst_n         (arst_n),
		.link_enable    (link_enable),
		.frame_select_n (frame_select_n),
		.serial_data    (serial_data),
		.shift_clock    (shift_clock),
		.word           (word),
		.word_valid     (word_valid),
		.frame_abort    (frame_abort)
	);

	assign ch   = word[`CHANNEL_SELECT_HIGH:`CHANNEL_SELECT_LOW];
	assign op   = quad_dac_pkg::op_mode_t'(
		word[`OPERATION_FIELD_HIGH:`OPERATION_FIELD_LOW]);
	assign code = word[`CODE_HIGH:`CODE_LOW];
	assign mask = load_mask(op, ch);

	// Only a completed frame loads a channel register.
	for (genvar i = 0; i < 4; i++)
	begin : g_load
		assign next_channel_reg[i] = (word_valid && mask[i]) ? code :
			channel_reg[i];
	end

	always_comb
	begin
		next_outputs      = channel_outputs;
		next_powered_down = powered_down;
		next_termination  = termination;
		next_last_word    = last_word;
		next_frame_count  = frame_count;
		if (word_valid)
		begin
			next_last_word   = word;
			next_frame_count = frame_count + 16'h0001;
			if (op == quad_dac_pkg::OP_POWER_DOWN)
			begin
				next_powered_down = 1'b1;
				next_termination  = quad_dac_pkg::term_t'(ch);
			end
			else
			begin
				next_powered_down = 1'b0;
				if (updates_outputs(op))
				begin
					next_outputs = next_channel_reg;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (int i = 0; i < 4; i++)
			begin
				channel_reg[i]     <= `CODE_RESET;
				channel_outputs[i] <= `CODE_RESET;
			end
			powered_down <= 1'b0;
			termination  <= quad_dac_pkg::TERM_HIGH_Z;
			last_word    <= 16'h0000;
			frame_count  <= 16'h0000;
		end
		else
		begin
			channel_reg     <= next_channel_reg;
			channel_outputs <= next_outputs;
			powered_down    <= next_powered_down;
			termination     <= next_termination;
			last_word       <= next_last_word;
			frame_count     <= next_frame_count;
		end
	end

	// Wishbone slave: ack one cycle after the strobe, writes act at ack.
	assign bus_hit   = wb_cyc & wb_stb;
	assign bus_write = bus_hit & wb_we & wb_ack;
	assign word_adr  = {wb_adr[7:2], 2'b00};

	always_comb
	begin
		next_ack         = bus_hit & ~wb_ack;
		next_dat_r       = wb_dat_r;
		next_link_enable = link_enable;
		// A new event wins over a clear in the same cycle.
		next_abort_seen  = frame_abort | abort_seen;
		next_frame_seen  = word_valid | frame_seen;
		if (bus_write && wb_sel[0])
		begin
			if (word_adr == `CTRL_OFFSET)
			begin
				next_link_enable = wb_dat_w[`CTRL_LINK_ENABLE_BIT];
			end
			if (word_adr == `STATUS_OFFSET)
			begin
				next_abort_seen = frame_abort |
					(abort_seen & ~wb_dat_w[`STATUS_ABORT_BIT]);
				next_frame_seen = word_valid |
					(frame_seen & ~wb_dat_w[`STATUS_FRAME_BIT]);
			end
		end
		if (bus_hit && !wb_ack)
		begin
			next_dat_r = 32'h0000_0000;
			case (wb_adr[7:4])
				4'h0:
				begin
					case (word_adr)
						`CTRL_OFFSET:
							next_dat_r[`CTRL_LINK_ENABLE_BIT] = link_enable;
						`STATUS_OFFSET:
						begin
							next_dat_r[`STATUS_POWERED_DOWN_BIT] = powered_down;
							next_dat_r[`STATUS_TERM_HIGH_BIT:
								`STATUS_TERM_LOW_BIT] = termination;
							next_dat_r[`STATUS_ABORT_BIT] = abort_seen;
							next_dat_r[`STATUS_FRAME_BIT] = frame_seen;
						end
						`LAST_WORD_OFFSET:
							next_dat_r[15:0] = last_word;
						`FRAME_COUNT_OFFSET:
							next_dat_r[15:0] = frame_count;
						default:
							next_dat_r = 32'h0000_0000;
					endcase
				end
				`CHANNEL_REG_PAGE:
					next_dat_r[9:0] = channel_reg[wb_adr[3:2]];
				`CHANNEL_OUT_PAGE:
					next_dat_r[9:0] = channel_outputs[wb_adr[3:2]];
				default:
					next_dat_r = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			wb_ack      <= 1'b0;
			wb_dat_r    <= 32'h0000_0000;
			link_enable <= `CTRL_RESET;
			abort_seen  <= 1'b0;
			frame_seen  <= 1'b0;
		end
		else
		begin
			wb_ack      <= next_ack;
			wb_dat_r    <= next_dat_r;
			link_enable <= next_link_enable;
			abort_seen  <= next_abort_seen;
			frame_seen  <= next_frame_seen;
		end
	end

	pd_enter_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		word_valid && op == quad_dac_pkg::OP_POWER_DOWN
		|=> powered_down && termination == $past(ch))
		else $error("power down or termination not taken");

	pd_exit_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		word_valid && op != quad_dac_pkg::OP_POWER_DOWN |=> !powered_down)
		else $error("normal frame did not leave power down");

	pd_keep_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		word_valid && op == quad_dac_pkg::OP_POWER_DOWN
		|=> $stable(channel_reg) && $stable(channel_outputs))
		else $error("power down altered a channel register");

	load_only_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		word_valid && op == quad_dac_pkg::OP_LOAD
		|=> $stable(channel_outputs) && channel_reg[$past(ch)] == $past(code))
		else $error("load without update misbehaved");

	load_all_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		word_valid && op == quad_dac_pkg::OP_LOAD_ALL
		|=> channel_outputs[0] == $past(code) &&
			channel_outputs[3] == $past(code) && channel_reg[2] == $past(code))
		else $error("load all and update misbehaved");

	code_field_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		word_valid && op == quad_dac_pkg::OP_LOAD_UPDATE
		|=> channel_outputs[$past(ch)] == $past(word[11:2]))
		else $error("code not taken from top ten data bits");

	no_frame_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!word_valid |=> $stable(channel_reg) && $stable(channel_outputs) &&
			$stable(powered_down))
		else $error("state changed without a complete frame");

	bus_ack_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
		bus_hit && !wb_ack |=> wb_ack ##1 !wb_ack)
		else $error("wishbone ack not one cycle after strobe");

	cover_update_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
		word_valid && op == quad_dac_pkg::OP_LOAD_UPDATE);

	cover_wake_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
		powered_down && word_valid && op != quad_dac_pkg::OP_POWER_DOWN);

	cover_abort_c: cover property (@(posedge ref_clk) disable iff (!arst_n)
		frame_abort);

endmodule
